/* File: logic/dchp_pkg.sv */
// Shared constants of the disk controller host port: register selects, reset values,
// status and command fields, strobe timing and the controller's own register map.
// Assumes one system clock of 25 MHz for both ends.
package dchp_pkg;
	// ****************************************
	// Device register selects and reset values
	// ****************************************
	localparam logic [1:0] SEL_CMD_STATUS = 2'h0;
	localparam logic [1:0] SEL_TRACK = 2'h1;
	localparam logic [1:0] SEL_SECTOR = 2'h2;
	localparam logic [1:0] SEL_DATA = 2'h3;
	localparam logic [7:0] COMMAND_RESET = 8'h03;
	localparam logic [7:0] SECTOR_RESET = 8'h01;
	localparam logic [7:0] TRACK_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam int STAT_NOT_READY_BIT = 7;
	localparam int CMD_SIDE_BIT = 1;
	localparam logic [3:0] CMD_FORCE_INT_CODE = 4'hD;

	// ****************************************
	// Timing
	// ****************************************
	localparam int SYS_CLK_KHZ = 25000;
	localparam int REF_KHZ_8IN = 2000;
	localparam int REF_KHZ_MINI = 1000;
	localparam int REF_HALF_8IN = SYS_CLK_KHZ / (2 * REF_KHZ_8IN);
	localparam int REF_HALF_MINI = SYS_CLK_KHZ / (2 * REF_KHZ_MINI);
	localparam int SETUP_CYCLES = 1;
	localparam int STROBE_CYCLES = 3;
	localparam int HOLD_CYCLES = 1;

	// ****************************************
	// Controller registers on AHB-Lite
	// ****************************************
	localparam logic [7:0] HOST_ACCESS_OFS = 8'h00;
	localparam logic [7:0] HOST_RESULT_OFS = 8'h04;
	localparam logic [7:0] HOST_EVENT_OFS = 8'h08;
	localparam logic [7:0] HOST_MASK_OFS = 8'h0C;
	localparam logic [7:0] HOST_CONTROL_OFS = 8'h10;
	localparam int ACC_SEL_LSB = 8;
	localparam int ACC_WRITE_BIT = 10;
	localparam int RES_BUSY_BIT = 8;
	localparam int RES_IRQ_BIT = 9;
	localparam int RES_DRQ_BIT = 10;
	localparam int EVT_DONE_BIT = 0;
	localparam int EVT_IRQ_BIT = 1;
	localparam int EVT_DRQ_BIT = 2;
	localparam int CTL_RESET_BIT = 0;
	localparam int CTL_MINI_BIT = 1;
	localparam logic [2:0] EVENT_RESET = 3'h0;
	localparam logic [2:0] MASK_RESET = 3'h0;
	localparam logic [1:0] CONTROL_RESET = 2'h0;
endpackage

/* File: logic/dchp_bus_if.sv */
// Multiplexed 8-bit processor bus between controller and disk controller device.
// Assumes both ends share one clock; the shared data bus is resolved here with pull-ups.
`timescale 1ns/1ns
interface dchp_bus_if;
	logic master_reset_n;
	logic chip_select_n;
	logic host_write_strobe_n;
	logic host_read_strobe_n;
	logic [1:0] register_select;
	logic [7:0] host_data_o;
	logic host_data_oe;
	logic [7:0] device_data_o;
	logic device_data_oe;
	logic [7:0] host_data_bus;
	logic command_done_irq;
	logic byte_transfer_request;
	logic timing_ref_clk;

	// Undriven lines float high through pull-ups
	assign host_data_bus = device_data_oe ? device_data_o :
		(host_data_oe ? host_data_o : 8'hFF);

	modport device_mp (
		input master_reset_n, chip_select_n, host_write_strobe_n, host_read_strobe_n,
		input register_select, host_data_bus, timing_ref_clk,
		output device_data_o, device_data_oe, command_done_irq, byte_transfer_request
	);
	modport host_mp (
		output master_reset_n, chip_select_n, host_write_strobe_n, host_read_strobe_n,
		output register_select, host_data_o, host_data_oe, timing_ref_clk,
		input host_data_bus, command_done_irq, byte_transfer_request
	);
endinterface

/* File: logic/dchp_device.sv */
// Disk controller device end: host register port, master reset and restore start.
// Assumes the command, stepping and data units sit on the user-side ports.
//
// Functional notes
// R1 - Master reset low loads command 03
// R2 - Not-ready status bit clear during reset
// R3 - Reset release starts restore, ready ignored
// R4 - Master reset loads sector register 01
// R5 - Write strobe with select latches bus
// R6 - Read strobe with select drives register
// R7 - Chip select low gates all access
// R8 - Select decodes status/command, track, sector, data
// R9 - 8-bit bus, inverted or true option
// R10 - Host supplies free-running 2/1 MHz reference
// R11 - Single-density option ignores density input
// R12 - Option gives side select output
// R13 - Irq on completion, cleared status/command
// R14 - Data request set, cleared by access
// R15 - Side select 0 in reset, updates at command
// R16 - Bus undriven unless chip and read selected
`timescale 1ns/1ns
module dchp_device #(
	parameter bit INVERTED_BUS = 1'b0,
	parameter bit HAS_SIDE_SELECT = 1'b1,
	parameter bit SINGLE_DENSITY = 1'b0
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	dchp_bus_if.device_mp bus,
	output logic cmd_start_o,
	output logic [7:0] cmd_code_o,
	output logic cmd_ignore_ready_o,
	input wire logic cmd_done_i,
	input wire logic [5:0] status_flags_i,
	input wire logic drive_ready_i,
	input wire logic data_load_i,
	input wire logic [7:0] data_in_i,
	input wire logic data_take_i,
	output logic [7:0] data_out_o,
	input wire logic track_load_i,
	input wire logic [7:0] track_in_i,
	output logic [7:0] track_o,
	output logic [7:0] sector_o,
	input wire logic density_select_n_i,
	output logic mfm_mode_o,
	input wire logic read_gate_i,
	output logic side_select_out_o,
	output logic ref_tick_o
);
	// ****************************************
	// Strobe decode
	// ****************************************
	logic wr_act, rd_act, wr_act_q, rd_act_q, wr_pulse, rd_pulse, mr_n, mr_q, restore_go;
	logic [7:0] bus_in;
	logic [1:0] sel;

	assign mr_n = bus.master_reset_n;
	assign sel = bus.register_select;
	assign wr_act = ~bus.chip_select_n & ~bus.host_write_strobe_n & mr_n; // R7
	assign rd_act = ~bus.chip_select_n & ~bus.host_read_strobe_n; // R7
	// One action per strobe, taken in its first cycle
	assign wr_pulse = wr_act & ~wr_act_q;
	assign rd_pulse = rd_act & ~rd_act_q;
	assign bus_in = INVERTED_BUS ? ~bus.host_data_bus : bus.host_data_bus; // R9
	assign restore_go = mr_n & ~mr_q; // R3

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_act_q <= 1'b0;
			rd_act_q <= 1'b0;
			mr_q <= 1'b0;
		end else begin
			wr_act_q <= wr_act;
			rd_act_q <= rd_act;
			mr_q <= mr_n;
		end
	end

	// ****************************************
	// Drive-side synchronisers
	// ****************************************
	logic [1:0] ready_sync_q, dens_sync_q;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ready_sync_q <= 2'h0;
			dens_sync_q <= 2'h3;
		end else begin
			ready_sync_q <= {ready_sync_q[0], drive_ready_i};
			dens_sync_q <= {dens_sync_q[0], density_select_n_i};
		end
	end

	// Single density builds never look at the density pin
	assign mfm_mode_o = SINGLE_DENSITY ? 1'b0 : ~dens_sync_q[1]; // R11

	// ****************************************
	// Command register and command start
	// ****************************************
	logic [7:0] command_q;
	logic cmd_start_q, ignore_ready_q, busy_q, host_cmd_wr;

	assign host_cmd_wr = wr_pulse & (sel == dchp_pkg::SEL_CMD_STATUS); // R8

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			command_q <= dchp_pkg::COMMAND_RESET;
		end else if (!mr_n) begin
			command_q <= dchp_pkg::COMMAND_RESET; // R1
		end else if (host_cmd_wr) begin
			command_q <= bus_in; // R5
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cmd_start_q <= 1'b0;
			ignore_ready_q <= 1'b0;
		end else begin
			cmd_start_q <= restore_go | host_cmd_wr;
			if (restore_go) begin
				ignore_ready_q <= 1'b1; // R3
			end else if (host_cmd_wr) begin
				ignore_ready_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy_q <= 1'b0;
		end else if (!mr_n) begin
			busy_q <= 1'b0;
		end else if (cmd_start_q) begin
			busy_q <= 1'b1;
		end else if (cmd_done_i) begin
			busy_q <= 1'b0;
		end
	end

	assign cmd_start_o = cmd_start_q;
	assign cmd_code_o = command_q;
	assign cmd_ignore_ready_o = ignore_ready_q;

	// ****************************************
	// Track, sector and data registers
	// ****************************************
	logic [7:0] track_q, sector_q, data_q;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			track_q <= dchp_pkg::TRACK_RESET;
		end else if (track_load_i) begin
			track_q <= track_in_i;
		end else if (wr_pulse && sel == dchp_pkg::SEL_TRACK) begin
			track_q <= bus_in; // R5
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sector_q <= dchp_pkg::SECTOR_RESET;
		end else if (!mr_n) begin
			sector_q <= dchp_pkg::SECTOR_RESET; // R4
		end else if (wr_pulse && sel == dchp_pkg::SEL_SECTOR) begin
			sector_q <= bus_in; // R5
		end
	end

	// The data unit wins a same-cycle collision with a host write
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			data_q <= dchp_pkg::DATA_RESET;
		end else if (data_load_i) begin
			data_q <= data_in_i;
		end else if (wr_pulse && sel == dchp_pkg::SEL_DATA) begin
			data_q <= bus_in; // R5
		end
	end

	assign track_o = track_q;
	assign sector_o = sector_q;
	assign data_out_o = data_q;

	// ****************************************
	// Interrupt and data request flags
	// ****************************************
	logic irq_q, drq_q, irq_clr, drq_clr;

	assign irq_clr = host_cmd_wr | (rd_pulse & (sel == dchp_pkg::SEL_CMD_STATUS));
	assign drq_clr = (wr_pulse | rd_pulse) & (sel == dchp_pkg::SEL_DATA);

	// Set wins over an access clear in the same cycle; master reset wins over set
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_q <= 1'b0;
		end else if (!mr_n) begin
			irq_q <= 1'b0;
		end else if (cmd_done_i) begin
			irq_q <= 1'b1; // R13
		end else if (irq_clr) begin
			irq_q <= 1'b0; // R13
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			drq_q <= 1'b0;
		end else if (!mr_n) begin
			drq_q <= 1'b0;
		end else if (data_load_i | data_take_i) begin
			drq_q <= 1'b1; // R14
		end else if (drq_clr) begin
			drq_q <= 1'b0; // R14
		end
	end

	assign bus.command_done_irq = irq_q;
	assign bus.byte_transfer_request = drq_q;

	// ****************************************
	// Read path
	// ****************************************
	logic [7:0] status_val, rd_val, dout_q;

	always_comb begin
		status_val = {1'b0, status_flags_i, busy_q};
		status_val[dchp_pkg::STAT_NOT_READY_BIT] = mr_n & ~ready_sync_q[1]; // R2
		case (sel) // R8
			dchp_pkg::SEL_CMD_STATUS: rd_val = status_val;
			dchp_pkg::SEL_TRACK: rd_val = track_q;
			dchp_pkg::SEL_SECTOR: rd_val = sector_q;
			default: rd_val = data_q;
		endcase
	end

	// Registered read data: valid from the second strobe cycle on
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dout_q <= 8'h00;
		end else begin
			dout_q <= INVERTED_BUS ? ~rd_val : rd_val; // R6 R9
		end
	end

	assign bus.device_data_o = dout_q;
	assign bus.device_data_oe = rd_act; // R6 R16

	// ****************************************
	// Side select and timing reference
	// ****************************************
	logic side_q, ref_q;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			side_q <= 1'b0;
		end else if (!mr_n) begin
			side_q <= 1'b0; // R15
		end else if (cmd_start_q && command_q[7] &&
			command_q[7:4] != dchp_pkg::CMD_FORCE_INT_CODE) begin
			side_q <= command_q[dchp_pkg::CMD_SIDE_BIT]; // R15
		end
	end

	// Without the option the pin carries the read gate instead
	assign side_select_out_o = HAS_SIDE_SELECT ? side_q : read_gate_i; // R12

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ref_q <= 1'b0;
		end else begin
			ref_q <= bus.timing_ref_clk;
		end
	end

	assign ref_tick_o = bus.timing_ref_clk & ~ref_q; // R10
endmodule

/* File: logic/dchp_host.sv */
// Controller end: AHB-Lite register slave that runs single device bus cycles,
// drives master reset and the timing reference, and raises a maskable interrupt.
// Assumes a zero-wait AHB-Lite master on the same clock.
`timescale 1ns/1ns
module dchp_host #(
	parameter bit INVERTED_BUS = 1'b0
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	dchp_bus_if.host_mp bus,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	output logic irq_o
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SETUP = 4'h2,
		ST_STROBE = 4'h4,
		ST_HOLD = 4'h8
	} dchp_state_type;

	// ****************************************
	// AHB-Lite slave, zero wait states
	// ****************************************
	logic [7:0] addr_q, rdata_q;
	logic wr_q;
	logic [31:0] hrdata_q, rd_mux;
	logic [2:0] evt_q, mask_q, evt_set;
	logic [1:0] ctl_q;
	logic ahb_wr, start;
	dchp_state_type state_q;

	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign ahb_wr = wr_q;
	assign start = ahb_wr & (addr_q == dchp_pkg::HOST_ACCESS_OFS) & (state_q == ST_IDLE);

	always_comb begin
		rd_mux = 32'h0;
		case (haddr_i[7:0])
			dchp_pkg::HOST_RESULT_OFS: begin
				rd_mux[7:0] = rdata_q;
				rd_mux[dchp_pkg::RES_BUSY_BIT] = state_q != ST_IDLE;
				rd_mux[dchp_pkg::RES_IRQ_BIT] = bus.command_done_irq;
				rd_mux[dchp_pkg::RES_DRQ_BIT] = bus.byte_transfer_request;
			end
			dchp_pkg::HOST_EVENT_OFS: rd_mux[2:0] = evt_q;
			dchp_pkg::HOST_MASK_OFS: rd_mux[2:0] = mask_q;
			dchp_pkg::HOST_CONTROL_OFS: rd_mux[1:0] = ctl_q;
			default: rd_mux = 32'h0;
		endcase
	end

	// Read data is fixed in the address phase, so a read straight after a write
	// to the same register shows the value before that write
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			addr_q <= 8'h00;
			wr_q <= 1'b0;
			hrdata_q <= 32'h0;
		end else begin
			wr_q <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
			addr_q <= haddr_i[7:0];
			if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
				hrdata_q <= rd_mux;
			end
		end
	end

	assign hrdata_o = hrdata_q;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mask_q <= dchp_pkg::MASK_RESET;
			ctl_q <= dchp_pkg::CONTROL_RESET;
		end else if (ahb_wr) begin
			if (addr_q == dchp_pkg::HOST_MASK_OFS) begin
				mask_q <= hwdata_i[2:0];
			end
			if (addr_q == dchp_pkg::HOST_CONTROL_OFS) begin
				ctl_q <= hwdata_i[1:0];
			end
		end
	end

	// ****************************************
	// Events and interrupt
	// ****************************************
	logic irq_in_q, drq_in_q, done_pulse;
	logic [2:0] evt_clr;

	assign evt_set[dchp_pkg::EVT_DONE_BIT] = done_pulse;
	assign evt_set[dchp_pkg::EVT_IRQ_BIT] = bus.command_done_irq & ~irq_in_q;
	assign evt_set[dchp_pkg::EVT_DRQ_BIT] = bus.byte_transfer_request & ~drq_in_q;
	assign evt_clr = (ahb_wr && addr_q == dchp_pkg::HOST_EVENT_OFS) ? hwdata_i[2:0] : 3'h0;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			evt_q <= dchp_pkg::EVENT_RESET;
			irq_in_q <= 1'b0;
			drq_in_q <= 1'b0;
		end else begin
			evt_q <= (evt_q & ~evt_clr) | evt_set;
			irq_in_q <= bus.command_done_irq;
			drq_in_q <= bus.byte_transfer_request;
		end
	end

	assign irq_o = |(evt_q & mask_q);

	// ****************************************
	// Device bus cycle
	// ****************************************
	logic [3:0] cnt_q;
	logic [1:0] sel_q;
	logic [7:0] wdata_q;
	logic dir_wr_q, cs_n_q, we_n_q, re_n_q, oe_q;

	assign done_pulse = (state_q == ST_HOLD) && (cnt_q == 4'h0);

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= ST_IDLE;
			cnt_q <= 4'h0;
			sel_q <= 2'h0;
			wdata_q <= 8'h00;
			dir_wr_q <= 1'b0;
			cs_n_q <= 1'b1;
			we_n_q <= 1'b1;
			re_n_q <= 1'b1;
			oe_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						sel_q <= hwdata_i[dchp_pkg::ACC_SEL_LSB +: 2];
						dir_wr_q <= hwdata_i[dchp_pkg::ACC_WRITE_BIT];
						wdata_q <= INVERTED_BUS ? ~hwdata_i[7:0] : hwdata_i[7:0]; // R9
						cs_n_q <= 1'b0; // R7
						cnt_q <= 4'(dchp_pkg::SETUP_CYCLES - 1);
						state_q <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					if (cnt_q == 4'h0) begin
						we_n_q <= ~dir_wr_q; // R5
						re_n_q <= dir_wr_q; // R6
						oe_q <= dir_wr_q;
						cnt_q <= 4'(dchp_pkg::STROBE_CYCLES - 1);
						state_q <= ST_STROBE;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ST_STROBE: begin
					if (cnt_q == 4'h0) begin
						if (!dir_wr_q) begin
							rdata_q <= INVERTED_BUS ? ~bus.host_data_bus : bus.host_data_bus;
						end
						we_n_q <= 1'b1;
						re_n_q <= 1'b1;
						cnt_q <= 4'(dchp_pkg::HOLD_CYCLES - 1);
						state_q <= ST_HOLD;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ST_HOLD: begin
					if (cnt_q == 4'h0) begin
						cs_n_q <= 1'b1;
						oe_q <= 1'b0;
						state_q <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	assign bus.chip_select_n = cs_n_q;
	assign bus.host_write_strobe_n = we_n_q;
	assign bus.host_read_strobe_n = re_n_q;
	assign bus.register_select = sel_q;
	assign bus.host_data_o = wdata_q;
	assign bus.host_data_oe = oe_q;
	assign bus.master_reset_n = ~ctl_q[dchp_pkg::CTL_RESET_BIT];

	// ****************************************
	// Free-running timing reference
	// ****************************************
	// 25 MHz does not divide evenly to 2 MHz; the half period rounds down
	logic [3:0] div_q;
	logic ref_q;
	logic [3:0] half;

	assign half = ctl_q[dchp_pkg::CTL_MINI_BIT] ? 4'(dchp_pkg::REF_HALF_MINI) :
		4'(dchp_pkg::REF_HALF_8IN);

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_q <= 4'h0;
			ref_q <= 1'b0;
		end else if (div_q >= half - 4'h1) begin
			div_q <= 4'h0;
			ref_q <= ~ref_q; // R10
		end else begin
			div_q <= div_q + 4'h1;
		end
	end

	assign bus.timing_ref_clk = ref_q;
endmodule

/* File: verification/dchp_bus_properties.sv */
// Checker of the device bus: strobe gating, reset values and flag clearing.
// Assumes true bus polarity and the interface signals wired in as plain inputs.
`timescale 1ns/1ns
module dchp_bus_properties (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic master_reset_n,
	input wire logic chip_select_n,
	input wire logic host_write_strobe_n,
	input wire logic host_read_strobe_n,
	input wire logic [1:0] register_select,
	input wire logic host_data_oe,
	input wire logic device_data_oe,
	input wire logic [7:0] host_data_bus,
	input wire logic command_done_irq,
	input wire logic byte_transfer_request
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	logic [7:0] sector_q;

	// ****************************************
	// Shadow of the sector register
	// ****************************************
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sector_q <= dchp_pkg::SECTOR_RESET;
		end else if (!master_reset_n) begin
			sector_q <= dchp_pkg::SECTOR_RESET;
		end else if (!chip_select_n && !host_write_strobe_n &&
			register_select == dchp_pkg::SEL_SECTOR) begin
			sector_q <= host_data_bus;
		end
	end

	sequence rd_go(logic [1:0] s);
		$fell(host_read_strobe_n) && !chip_select_n && register_select == s;
	endsequence
	sequence wr_go(logic [1:0] s);
		$fell(host_write_strobe_n) && !chip_select_n && register_select == s;
	endsequence

	// ****************************************
	// Properties
	// ****************************************
	a_oe_needs_read: assert property (device_data_oe |-> !chip_select_n && !host_read_strobe_n)
		else $error("device drives bus outside a read");
	a_oe_on_read: assert property (!chip_select_n && !host_read_strobe_n |-> device_data_oe)
		else $error("device silent during a read");
	a_quiet_unselected: assert property (chip_select_n |-> !device_data_oe)
		else $error("device drives bus while not selected");
	a_no_contention: assert property (!(device_data_oe && host_data_oe))
		else $error("both ends drive the bus");
	a_ready_clear_mr: assert property (rd_go(dchp_pkg::SEL_CMD_STATUS) ##0 !master_reset_n
		|=> !host_data_bus[7]) else $error("not ready bit set in master reset");
	a_sector_readback: assert property (rd_go(dchp_pkg::SEL_SECTOR) |=> host_data_bus == sector_q)
		else $error("sector read differs from last write");
	a_irq_status_clear: assert property (rd_go(dchp_pkg::SEL_CMD_STATUS) |=> !command_done_irq)
		else $error("status read left irq set");
	a_irq_cmd_clear: assert property (wr_go(dchp_pkg::SEL_CMD_STATUS) ##0 master_reset_n
		|=> !command_done_irq) else $error("command write left irq set");
	a_drq_data_clear: assert property ($fell(host_read_strobe_n && host_write_strobe_n) &&
		!chip_select_n && register_select == dchp_pkg::SEL_DATA |=> !byte_transfer_request)
		else $error("data access left request set");
	a_mr_clears_flags: assert property (!master_reset_n ##1 !master_reset_n
		|=> !command_done_irq && !byte_transfer_request) else $error("flags set in master reset");
endmodule

/* File: verification/test_disk_ctrl_host_register_port.sv */
// Self-checking bench: controller and device joined by the bus interface.
// Assumes the default parameters of both ends and a 25 MHz clock.
`timescale 1ns/1ns
module test_disk_ctrl_host_register_port;
	logic clock_i = 1'b0, rstn_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
	logic [1:0] htrans_i = 2'h0;
	logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, r;
	logic hreadyout_o, hresp_o, irq_o, cmd_start_o, cmd_ignore_ready_o, side_select_out_o;
	logic cmd_done_i = 1'b0, data_load_i = 1'b0, data_take_i = 1'b0, track_load_i = 1'b0;
	logic [5:0] status_flags_i = 6'h15;
	logic [7:0] cmd_code_o, q, data_in_i = 8'h00, track_in_i = 8'h00, code_seen = 8'h00;
	logic ign_seen = 1'b0, ref_tick_o;
	int failures = 0, n_checks = 0, cycles = 0, starts = 0, s0, gap = 0, tick_at = 0;
	logic [7:0] vals [3] = '{8'h5A, 8'hA5, 8'h3C};
	dchp_bus_if bus_if();
	// Drive ready held low: the restore after reset must not wait for it
	dchp_device dchp_device_inst (.clock_i, .rstn_i, .bus(bus_if), .cmd_start_o, .cmd_code_o,
		.cmd_ignore_ready_o, .cmd_done_i, .status_flags_i, .drive_ready_i(1'b0), .data_load_i,
		.data_in_i, .data_take_i, .data_out_o(), .track_load_i, .track_in_i, .track_o(),
		.sector_o(), .density_select_n_i(1'b1), .mfm_mode_o(), .read_gate_i(1'b0),
		.side_select_out_o, .ref_tick_o);
	dchp_host dchp_host_inst (.clock_i, .rstn_i, .bus(bus_if), .hsel_i, .haddr_i, .htrans_i,
		.hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o,
		.hrdata_o, .irq_o);
	dchp_bus_properties dchp_bus_properties_inst (.clock_i, .rstn_i,
		.master_reset_n(bus_if.master_reset_n), .chip_select_n(bus_if.chip_select_n),
		.host_write_strobe_n(bus_if.host_write_strobe_n),
		.host_read_strobe_n(bus_if.host_read_strobe_n), .register_select(bus_if.register_select),
		.host_data_oe(bus_if.host_data_oe), .device_data_oe(bus_if.device_data_oe),
		.host_data_bus(bus_if.host_data_bus), .command_done_irq(bus_if.command_done_irq),
		.byte_transfer_request(bus_if.byte_transfer_request));

	// ****************************************
	// Clock, monitor and timeout
	// ****************************************
	always #20 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cycles++;
		if (cmd_start_o === 1'b1) begin
			starts++;
			code_seen = cmd_code_o;
			ign_seen = cmd_ignore_ready_o;
		end
		if (ref_tick_o === 1'b1) begin
			gap = cycles - tick_at;
			tick_at = cycles;
		end
		if (cycles == 20000) begin
			failures++;
			wrap_up();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel_i <= 1'b1;
		haddr_i <= {24'h0, a};
		htrans_i <= 2'h2;
		hwrite_i <= wr;
		do @(posedge clock_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hsel_i <= 1'b0;
		hwdata_i <= wd;
		do @(posedge clock_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
	endtask
	// One device bus cycle: start it, wait for the done event, clear it, fetch the byte
	task automatic dev(input logic [1:0] sel, input logic wr, input logic [7:0] d,
		output logic [7:0] rq);
		logic [31:0] x;
		int k;
		ahb(1'b1, dchp_pkg::HOST_ACCESS_OFS, {21'h0, wr, sel, d}, x);
		k = 0;
		x = 32'h0;
		while (x[dchp_pkg::EVT_DONE_BIT] !== 1'b1 && k < 50) begin
			ahb(1'b0, dchp_pkg::HOST_EVENT_OFS, 32'h0, x);
			k++;
		end
		if (k == 50) failures++;
		ahb(1'b1, dchp_pkg::HOST_EVENT_OFS, 32'h1, x);
		ahb(1'b0, dchp_pkg::HOST_RESULT_OFS, 32'h0, x);
		rq = x[7:0];
	endtask
	task automatic done_pulse;
		cmd_done_i <= 1'b1;
		@(posedge clock_i);
		cmd_done_i <= 1'b0;
		repeat (2) @(posedge clock_i);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_restore;
		repeat (4) @(posedge clock_i);
		check(starts, 1);
		check(ign_seen, 1'b1);
		check(code_seen, dchp_pkg::COMMAND_RESET);
		dev(dchp_pkg::SEL_SECTOR, 1'b0, 8'h00, q);
		check(q, dchp_pkg::SECTOR_RESET);
		dev(dchp_pkg::SEL_TRACK, 1'b0, 8'h00, q);
		check(q, dchp_pkg::TRACK_RESET);
		dev(dchp_pkg::SEL_CMD_STATUS, 1'b0, 8'h00, q);
		check(q[6:0], {status_flags_i, 1'b1});
		done_pulse();
		check(bus_if.command_done_irq, 1'b1);
		dev(dchp_pkg::SEL_CMD_STATUS, 1'b0, 8'h00, q);
		check(q[6:0], {status_flags_i, 1'b0});
		check(bus_if.command_done_irq, 1'b0);
		check(gap, 2 * dchp_pkg::REF_HALF_8IN);
		$display("restore test done");
	endtask
	task automatic t_regs;
		for (int i = 1; i < 4; i++) begin
			dev(2'(i), 1'b1, vals[i - 1], q);
		end
		for (int i = 1; i < 4; i++) begin
			dev(2'(i), 1'b0, 8'h00, q);
			check(q, vals[i - 1]);
		end
		track_in_i <= 8'h27;
		track_load_i <= 1'b1;
		@(posedge clock_i);
		track_load_i <= 1'b0;
		dev(dchp_pkg::SEL_TRACK, 1'b0, 8'h00, q);
		check(q, 8'h27);
		data_in_i <= 8'h81;
		data_load_i <= 1'b1;
		@(posedge clock_i);
		data_load_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		check(bus_if.byte_transfer_request, 1'b1);
		dev(dchp_pkg::SEL_DATA, 1'b0, 8'h00, q);
		check(q, 8'h81);
		check(bus_if.byte_transfer_request, 1'b0);
		data_take_i <= 1'b1;
		@(posedge clock_i);
		data_take_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		check(bus_if.byte_transfer_request, 1'b1);
		dev(dchp_pkg::SEL_DATA, 1'b1, 8'h42, q);
		check(bus_if.byte_transfer_request, 1'b0);
		$display("register test done");
	endtask
	task automatic t_cmd;
		ahb(1'b1, dchp_pkg::HOST_MASK_OFS, 32'h2, r);
		ahb(1'b1, dchp_pkg::HOST_EVENT_OFS, 32'h7, r);
		done_pulse();
		check(irq_o, 1'b1);
		ahb(1'b1, dchp_pkg::HOST_MASK_OFS, 32'h0, r);
		@(posedge clock_i);
		check(irq_o, 1'b0);
		ahb(0, 8'h20, 32'h0, r);
		check(r, 32'h0);
		dev(dchp_pkg::SEL_CMD_STATUS, 1'b1, 8'h82, q);
		repeat (3) @(posedge clock_i);
		check(code_seen, 8'h82);
		check(ign_seen, 1'b0);
		check(side_select_out_o, 1'b1);
		check(bus_if.command_done_irq, 1'b0);
		// A force-interrupt code is no sector or track command and keeps the side
		dev(dchp_pkg::SEL_CMD_STATUS, 1'b1, 8'hD0, q);
		repeat (3) @(posedge clock_i);
		check(side_select_out_o, 1'b1);
		done_pulse();
		$display("command test done");
	endtask
	task automatic t_mreset;
		ahb(1'b1, dchp_pkg::HOST_CONTROL_OFS, 32'h3, r);
		repeat (3) @(posedge clock_i);
		check(side_select_out_o, 1'b0);
		check(cmd_code_o, dchp_pkg::COMMAND_RESET);
		dev(dchp_pkg::SEL_CMD_STATUS, 1'b0, 8'h00, q);
		check(q[7], 1'b0);
		dev(dchp_pkg::SEL_SECTOR, 1'b1, 8'h77, q);
		dev(dchp_pkg::SEL_SECTOR, 1'b0, 8'h00, q);
		check(q, dchp_pkg::SECTOR_RESET);
		repeat (50) @(posedge clock_i);
		check(gap, 2 * dchp_pkg::REF_HALF_MINI);
		s0 = starts;
		ahb(1'b1, dchp_pkg::HOST_CONTROL_OFS, 32'h0, r);
		repeat (5) @(posedge clock_i);
		check(starts, s0 + 1);
		check(ign_seen, 1'b1);
		$display("master reset test done");
	endtask

	initial begin
		repeat (10) @(posedge clock_i);
		rstn_i <= 1'b1;
		t_restore();
		t_regs();
		t_cmd();
		t_mreset();
		wrap_up();
	end
endmodule
